//--- hw/rcmc_pkg.sv
/*
 package for the reset and clock mode controller.
 holds register offsets, field positions, reset values and mode codes.
 assumes nothing beyond a systemverilog compiler.
*/
package rcmc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [8:0] RCMC_CLOCK_CONTROL_REG_ADDR = 9'h00f;
   localparam logic [8:0] RCMC_TRIM_ADDR   = 9'h10f;
   localparam logic [7:0] RCMC_CLOCK_CONTROL_REG_RST  = 8'h03;
   localparam logic [7:0] RCMC_CLOCK_CONTROL_REG_MASK = 8'h1f;
   localparam logic [6:0] RCMC_TRIM_MASK   = 7'h7f;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int RCMC_SLOW_CLK_STOP_BIT = 4;
   localparam int RCMC_FAST_CLK_STOP_BIT = 3;
   localparam int RCMC_SEL_BIT     = 2;
   localparam int RCMC_PSC_LSB     = 0;
   // config word fields
   localparam int RCMC_CFG_WATCHDOG_ENABLE_FIELD_LSB   = 8;
   localparam int RCMC_CFG_EXT_RESET_PIN_BIT   = 10;
   localparam int RCMC_CFG_LVR_LSB    = 11;
   localparam int RCMC_CFG_FOSC_BIT   = 13;
   localparam int RCMC_CFG_MODE_LSB   = 14;
   localparam logic [1:0] RCMC_WATCHDOG_ENABLE_FIELD_ALWAYS = 2'h3;
   localparam logic [1:0] RCMC_WATCHDOG_ENABLE_FIELD_RUN    = 2'h2;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int RCMC_EXT_RESET_PIN_SLOW_CYC = 2;
   localparam int RCMC_SYNC_DEPTH    = 3;
   // ---------------------------------------------------------------
   // power modes
   // ---------------------------------------------------------------
   typedef enum logic [3:0]
   {
      RCMC_SLOW = 4'h1,
      RCMC_FAST = 4'h2,
      RCMC_IDLE = 4'h4,
      RCMC_STOP = 4'h8
   } rcmc_mode_t;
endpackage

//--- hw/rcmc_sync.sv
/*
 three flop synchroniser with agreement filter.
 assumes input is asynchronous to core_clk.
*/
`timescale 1ns/100ps
module rcmc_sync
   import rcmc_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic rst_val,
   // data
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed
   {
      logic [RCMC_SYNC_DEPTH-1:0] pipe;
      logic                       q;
   } rcmc_sync_st_t;
   rcmc_sync_st_t s;
   rcmc_sync_st_t next_s;
   // ---------------------------------------------------------------
   // shift and agree
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.pipe = {s.pipe[RCMC_SYNC_DEPTH-2:0], async_in};
      if (s.pipe[1] == s.pipe[2])
      begin
         next_s.q = s.pipe[2];
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '1;
      end
      else
      begin
         s <= next_s;
      end
   end
   assign sync_out = s.q | (rst_val & 1'b0);
endmodule

//--- hw/rcmc_reset_gen.sv
/*
 reset collector: merges low-voltage, pin and watchdog causes; power-on rst_n only clears its cause flops and sets the pin synchroniser flops.
 assumes slow_tick is a one-cycle pulse per slow oscillator period.
*/
`timescale 1ns/100ps
module rcmc_reset_gen
   import rcmc_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // causes
   input  wire logic lvr_low,
   input  wire logic ext_reset_pin_n,
   input  wire logic ext_reset_en,
   input  wire logic wdt_overflow,
   input  wire logic wdt_reset_en,
   input  wire logic slow_tick,
   // result
   output logic      sys_reset,
   output logic      warm_reset
);
   typedef struct packed
   {
      logic [1:0] low_cnt;
      logic       pin_rst;
      logic       wdt_rst;
   } rcmc_rg_st_t;
   rcmc_rg_st_t s;
   rcmc_rg_st_t next_s;
   logic        pin_sync;
   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   rcmc_sync u_pin_sync
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .rst_val  (1'b1),
      .async_in (ext_reset_pin_n),
      .sync_out (pin_sync)
   );
   // ---------------------------------------------------------------
   // qualify causes
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.wdt_rst = wdt_overflow & wdt_reset_en;
      if (!ext_reset_en || pin_sync)
      begin
         next_s.low_cnt = 2'h0;
         next_s.pin_rst = 1'b0;
      end
      else if (slow_tick)
      begin
         if (s.low_cnt == 2'(RCMC_EXT_RESET_PIN_SLOW_CYC))
         begin
            next_s.pin_rst = 1'b1;
         end
         else
         begin
            next_s.low_cnt = s.low_cnt + 2'h1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end
   assign warm_reset = s.pin_rst | s.wdt_rst;
   assign sys_reset  = warm_reset | lvr_low;
endmodule

//--- hw/rcmc_top.sv
/*
 reset and clock mode controller: clock control and trim registers,
 clock source selection, prescaler, power modes and status flags.
 assumes oscillators are enabled by the *_osc_en outputs and report
 readiness, and the cpu issues sleep and watchdog clear strobes.
*/
`timescale 1ns/100ps
module rcmc_top
   import rcmc_pkg::*;
#(
   parameter logic [6:0] TRIM_DEFAULT = 7'h40 // per-chip value, arbitrary
)
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [8:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // configuration
   input  wire logic [15:0] config_word,
   input  wire logic        lvr_low,
   input  wire logic        ext_reset_pin_n,
   // watchdog and cpu events
   input  wire logic       wdt_overflow,
   input  wire logic       watchdog_clear,
   input  wire logic       sleep_req,
   input  wire logic       t2_clk_select,
   input  wire logic       wake_timer_irq_en,
   // wake sources
   input  wire logic       ext_pin_irq,
   input  wire logic       wake_timer_irq,
   input  wire logic       time_base_irq,
   // oscillators
   input  wire logic       slow_tick,
   input  wire logic       fast_tick,
   input  wire logic       fast_ready,
   input  wire logic       slow_ready,
   output logic            fast_osc_en,
   output logic            slow_osc_en,
   output logic      [6:0] fast_osc_trim,
   // clock and mode outputs
   output logic            sys_clk_pulse,
   output logic            sys_src_fast,
   output logic            cpu_run,
   output logic            wdt_run,
   output logic            sys_reset,
   output logic      [3:0] power_mode,
   output logic            timeout_flag,
   output logic            powerdown_flag,
   output logic      [1:0] lvr_level,
   output logic      [1:0] chip_mode,
   output logic            fast_osc_cfg
);
   typedef struct packed
   {
      logic       slow_stp;
      logic       fast_stp;
      logic       sel;
      logic [1:0] psc;
      logic [6:0] trim;
      logic       src_fast;
      logic [2:0] div_cnt;
      logic       clk_pulse;
      rcmc_mode_t mode;
      logic       to_flag;
      logic       pd_flag;
      logic [15:0] cfg;
      logic       cfg_loaded;
   } rcmc_st_t;
   rcmc_st_t   s;
   rcmc_st_t   next_s;
   logic       warm_reset;
   logic       rst_any;
   logic       src_tick;
   logic [2:0] div_max;
   logic       slow_keep;
   logic       wr_ctl;
   logic       bad_wr;
   // ---------------------------------------------------------------
   // reset collection
   // ---------------------------------------------------------------
   rcmc_reset_gen u_reset_gen
   (
      .core_clk        (core_clk),
      .rst_n           (rst_n),
      .lvr_low         (lvr_low),
      .ext_reset_pin_n (ext_reset_pin_n),
      .ext_reset_en    (s.cfg[RCMC_CFG_EXT_RESET_PIN_BIT]),
      .wdt_overflow    (wdt_overflow),
      .wdt_reset_en    (s.cfg[RCMC_CFG_WATCHDOG_ENABLE_FIELD_LSB+1]),
      .slow_tick       (slow_tick),
      .sys_reset       (rst_any),
      .warm_reset      (warm_reset)
   );
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign wr_ctl    = reg_wr && (reg_addr == RCMC_CLOCK_CONTROL_REG_ADDR);
   assign bad_wr    = reg_wdata[RCMC_FAST_CLK_STOP_BIT] & reg_wdata[RCMC_SEL_BIT];
   assign slow_keep = wake_timer_irq_en
                      | (s.cfg[RCMC_CFG_WATCHDOG_ENABLE_FIELD_LSB+:2] == RCMC_WATCHDOG_ENABLE_FIELD_ALWAYS);
   assign src_tick  = s.src_fast ? fast_tick : slow_tick;
   always_comb
   begin
      case (s.psc)
         2'h0:    div_max = 3'h7;
         2'h1:    div_max = 3'h3;
         2'h2:    div_max = 3'h1;
         default: div_max = 3'h0;
      endcase
   end
   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.clk_pulse = 1'b0;
      if (!s.cfg_loaded)
      begin
         next_s.cfg = config_word;
         next_s.cfg_loaded = 1'b1;
      end
      if (rst_any)
      begin
         next_s.slow_stp = RCMC_CLOCK_CONTROL_REG_RST[RCMC_SLOW_CLK_STOP_BIT];
         next_s.fast_stp = RCMC_CLOCK_CONTROL_REG_RST[RCMC_FAST_CLK_STOP_BIT];
         next_s.sel      = RCMC_CLOCK_CONTROL_REG_RST[RCMC_SEL_BIT];
         next_s.psc      = RCMC_CLOCK_CONTROL_REG_RST[RCMC_PSC_LSB+:2];
         next_s.src_fast = 1'b0;
         next_s.div_cnt  = 3'h0;
         next_s.mode     = RCMC_SLOW;
         if (lvr_low)
         begin
            next_s.to_flag = 1'b0;
            next_s.pd_flag = 1'b0;
         end
      end
      else
      begin
         if (wr_ctl)
         begin
            next_s.slow_stp = reg_wdata[RCMC_SLOW_CLK_STOP_BIT];
            next_s.psc      = reg_wdata[RCMC_PSC_LSB+:2];
            if (!bad_wr)
            begin
               next_s.fast_stp = reg_wdata[RCMC_FAST_CLK_STOP_BIT];
               next_s.sel      = reg_wdata[RCMC_SEL_BIT];
            end
         end
         if (reg_wr && reg_addr == RCMC_TRIM_ADDR)
         begin
            next_s.trim = reg_wdata[6:0] & RCMC_TRIM_MASK;
         end
         if (s.sel != s.src_fast)
         begin
            if ((s.sel && fast_ready) || (!s.sel && slow_ready))
            begin
               next_s.src_fast = s.sel;
               next_s.div_cnt  = 3'h0;
            end
         end
         else if (src_tick && (s.mode == RCMC_FAST || s.mode == RCMC_SLOW))
         begin
            if (s.div_cnt >= div_max)
            begin
               next_s.div_cnt   = 3'h0;
               next_s.clk_pulse = 1'b1;
            end
            else
            begin
               next_s.div_cnt = s.div_cnt + 3'h1;
            end
         end
         if (watchdog_clear)
         begin
            next_s.to_flag = 1'b0;
            next_s.pd_flag = 1'b0;
         end
         case (s.mode)
            RCMC_FAST,
            RCMC_SLOW:
            begin
               next_s.mode = s.src_fast ? RCMC_FAST : RCMC_SLOW;
               if (sleep_req)
               begin
                  next_s.pd_flag = 1'b1;
                  next_s.to_flag = 1'b0;
                  if ((!s.slow_stp && !t2_clk_select) || slow_keep)
                  begin
                     next_s.mode = RCMC_IDLE;
                  end
                  else
                  begin
                     next_s.mode = RCMC_STOP;
                  end
               end
            end
            RCMC_IDLE:
            begin
               if (ext_pin_irq || wake_timer_irq || time_base_irq)
               begin
                  next_s.mode = s.src_fast ? RCMC_FAST : RCMC_SLOW;
               end
            end
            RCMC_STOP:
            begin
               if (ext_pin_irq)
               begin
                  next_s.mode = s.src_fast ? RCMC_FAST : RCMC_SLOW;
               end
            end
            default:
            begin
               next_s.mode = RCMC_SLOW;
            end
         endcase
         if (wdt_overflow)
         begin
            next_s.to_flag = 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s            <= '0;
         s.psc        <= RCMC_CLOCK_CONTROL_REG_RST[RCMC_PSC_LSB+:2];
         s.trim       <= TRIM_DEFAULT;
         s.mode       <= RCMC_SLOW;
      end
      else
      begin
         s <= next_s;
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb
   begin
      reg_rdata = 8'h00;
      if (reg_addr == RCMC_CLOCK_CONTROL_REG_ADDR)
      begin
         reg_rdata = {3'h0, s.slow_stp, s.fast_stp, s.sel, s.psc} & RCMC_CLOCK_CONTROL_REG_MASK;
      end
      else if (reg_addr == RCMC_TRIM_ADDR)
      begin
         reg_rdata = {1'b0, s.trim};
      end
   end
   assign fast_osc_en    = !s.fast_stp && (s.mode == RCMC_FAST || s.mode == RCMC_SLOW);
   assign slow_osc_en    = (s.mode != RCMC_STOP) && !(s.mode == RCMC_IDLE && s.slow_stp && !slow_keep)
                           ;
   assign fast_osc_trim  = s.trim;
   assign sys_clk_pulse  = s.clk_pulse;
   assign sys_src_fast   = s.src_fast;
   assign cpu_run        = (s.mode == RCMC_FAST) || (s.mode == RCMC_SLOW);
   assign wdt_run        = s.cfg[RCMC_CFG_WATCHDOG_ENABLE_FIELD_LSB+1] && (cpu_run
                           || s.cfg[RCMC_CFG_WATCHDOG_ENABLE_FIELD_LSB+:2] == RCMC_WATCHDOG_ENABLE_FIELD_ALWAYS);
   assign sys_reset      = rst_any;
   assign power_mode     = s.mode;
   assign timeout_flag   = s.to_flag;
   assign powerdown_flag = s.pd_flag;
   assign lvr_level      = s.cfg[RCMC_CFG_LVR_LSB+:2];
   assign chip_mode      = s.cfg[RCMC_CFG_MODE_LSB+:2];
   assign fast_osc_cfg   = s.cfg[RCMC_CFG_FOSC_BIT];
endmodule

//--- bench/rcmc_props.sv
/*
 port checker for rcmc_top: flags, modes, clock control.
 assumes binding to rcmc_top, one clock domain.
*/
`timescale 1ns/100ps
module rcmc_props
   import rcmc_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_n,
   // register port
   input wire logic [8:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // events
   input wire logic       lvr_low,
   input wire logic       wdt_overflow,
   input wire logic       watchdog_clear,
   input wire logic       sleep_req,
   input wire logic       ext_pin_irq,
   input wire logic       wake_timer_irq,
   input wire logic       time_base_irq,
   input wire logic       fast_ready,
   // results
   input wire logic       fast_osc_en,
   input wire logic       slow_osc_en,
   input wire logic       sys_src_fast,
   input wire logic       sys_reset,
   input wire logic [3:0] power_mode,
   input wire logic       timeout_flag,
   input wire logic       powerdown_flag
);
   // -----------------------------------------------------------
   // properties
   // -----------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire run_m = power_mode == RCMC_SLOW || power_mode == RCMC_FAST;
   wire rej_w = reg_wr && reg_addr == RCMC_CLOCK_CONTROL_REG_ADDR && reg_wdata[3:2] == 2'b11;
   property p_rej;
      rej_w && !sys_reset ##1 reg_addr == RCMC_CLOCK_CONTROL_REG_ADDR
         |-> reg_rdata[3:2] == $past(reg_rdata[3:2]) && reg_rdata[1:0] == $past(reg_wdata[1:0]);
   endproperty
   a_rej: assert property (p_rej) else $error("rejected write altered stop or select");
   property p_sleep;
      sleep_req && run_m && !wdt_overflow && !sys_reset
         |=> powerdown_flag && !timeout_flag && (power_mode == RCMC_IDLE || power_mode == RCMC_STOP);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep did not enter power-down");
   property p_clr;
      watchdog_clear && !wdt_overflow && !sleep_req |=> !powerdown_flag && !timeout_flag;
   endproperty
   a_clr: assert property (p_clr) else $error("watchdog clear left a flag set");
   property p_to;
      wdt_overflow && !lvr_low |=> timeout_flag;
   endproperty
   a_to: assert property (p_to) else $error("timeout flag not set");
   property p_stop;
      power_mode == RCMC_STOP && !ext_pin_irq && !sys_reset |=> power_mode == RCMC_STOP;
   endproperty
   a_stop: assert property (p_stop) else $error("stop left without pin wake");
   property p_idle;
      power_mode == RCMC_IDLE && (ext_pin_irq || wake_timer_irq || time_base_irq) && !sys_reset |=> run_m;
   endproperty
   a_idle: assert property (p_idle) else $error("idle did not wake");
   property p_lvr;
      lvr_low |-> sys_reset ##1 (power_mode == RCMC_SLOW && !timeout_flag && !powerdown_flag);
   endproperty
   a_lvr: assert property (p_lvr) else $error("reset not held on low supply");
   property p_rst;
      sys_reset [*2] |-> power_mode == RCMC_SLOW && !sys_src_fast;
   endproperty
   a_rst: assert property (p_rst) else $error("reset did not restore slow mode");
   property p_off;
      power_mode == RCMC_STOP |-> !fast_osc_en && !slow_osc_en;
   endproperty
   a_off: assert property (p_off) else $error("oscillator running in stop");
   property p_src;
      $rose(sys_src_fast) |-> $past(fast_ready);
   endproperty
   a_src: assert property (p_src) else $error("switched to fast source not ready");
   property p_fstop;
      reg_addr == RCMC_CLOCK_CONTROL_REG_ADDR && run_m && !sys_reset |-> fast_osc_en == !reg_rdata[3];
   endproperty
   a_fstop: assert property (p_fstop) else $error("fast enable disagrees with stop bit");
   // -----------------------------------------------------------
   // covers
   // -----------------------------------------------------------
   c_stop: cover property (power_mode == RCMC_STOP ##1 run_m);
   c_idle: cover property (power_mode == RCMC_IDLE ##1 run_m);
   c_rej: cover property (rej_w);
endmodule

bind rcmc_top rcmc_props u_props (.*);

//--- bench/test_reset_and_clock_mode_control.sv
/*
 bench for rcmc_top: registers, modes, resets, prescaler.
 assumes rcmc_props is bound to the design.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) \
   begin err_total++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module test_reset_and_clock_mode_control
   import rcmc_pkg::*;
;
   // -----------------------------------------------------------
   // signals
   // -----------------------------------------------------------
   logic        core_clk = 0;
   logic        rst_n = 0;
   logic [8:0]  reg_addr = 9'h000;
   logic        reg_wr = 0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic [15:0] config_word = 16'h7e00;
   logic        lvr_low = 0, ext_reset_pin_n = 1, wdt_overflow = 0, watchdog_clear = 0, sleep_req = 0;
   logic        wake_timer_irq_en = 0, ext_pin_irq = 0, wake_timer_irq = 0, time_base_irq = 0, fast_ready = 0;
   logic [1:0]  tk = 2'h0;
   logic        fast_osc_en, slow_osc_en, sys_clk_pulse, sys_src_fast, cpu_run, wdt_run, sys_reset;
   logic [6:0]  fast_osc_trim;
   logic [3:0]  power_mode;
   logic        timeout_flag, powerdown_flag, fast_osc_cfg, rs_seen = 0;
   logic [1:0]  lvr_level, chip_mode;
   int          err_total = 0, n_checks = 0, pc = 0;
   logic        t2_clk_select = 0, slow_ready = 1;

   rcmc_top #(.TRIM_DEFAULT(7'h2a)) u_dut (.*, .slow_tick(tk == 2'h0), .fast_tick(1'b1));

   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) #1 tk = tk + 2'h1;
   always @(negedge core_clk) if (sys_reset === 1'b1) rs_seen = 1;
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task wr(input logic [8:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      step(1);
      reg_wr = 0;
      step(1);
   endtask
   task rchk(input logic [8:0] a, input logic [7:0] e);
      reg_addr = a;
      #1 `CHK("reg_rdata", e, reg_rdata)
   endtask
   task settle();
      for (int i = 0; i < 60 && sys_reset !== 1'b0; i++) step(1);
      step(2);
   endtask
   task slp();
      sleep_req = 1;
      step(1);
      sleep_req = 0;
   endtask
   task pin_wake();
      ext_pin_irq = 1;
      step(1);
      ext_pin_irq = 0;
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task t_reset();
      rchk(RCMC_CLOCK_CONTROL_REG_ADDR, RCMC_CLOCK_CONTROL_REG_RST);
      rchk(9'h0aa, 8'h00);
      `CHK("trim", 7'h2a, fast_osc_trim)
      `CHK("mode", RCMC_SLOW, power_mode)
      `CHK("cfg", 5'h0f, {chip_mode, fast_osc_cfg, lvr_level})
      `CHK("flags", 2'h0, {timeout_flag, powerdown_flag})
      `CHK("run", 2'h3, {cpu_run, wdt_run})
      wr(RCMC_TRIM_ADDR, 8'h7f);
      `CHK("trim", 7'h7f, fast_osc_trim)
      wr(RCMC_TRIM_ADDR, 8'h00);
      `CHK("trim", 7'h00, fast_osc_trim)
   endtask
   task t_reject();
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h01);
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h0e);
      rchk(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h02);
      `CHK("src", 1'b0, sys_src_fast)
   endtask
   task t_switch();
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h07);
      step(4);
      `CHK("src", 1'b0, sys_src_fast)
      fast_ready = 1;
      step(3);
      `CHK("src", 1'b1, sys_src_fast)
      `CHK("mode", RCMC_FAST, power_mode)
      slow_ready = 0;
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h03);
      step(3);
      `CHK("src", 1'b1, sys_src_fast)
      slow_ready = 1;
      step(3);
      `CHK("src", 1'b0, sys_src_fast)
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h0b);
      `CHK("fast_en", 1'b0, fast_osc_en)
      fast_ready = 0;
   endtask
   task t_psc();
      for (int c = 0; c < 4; c++)
      begin
         wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'(c));
         step(40);
         pc = 0;
         repeat (64)
         begin
            step(1);
            if (sys_clk_pulse === 1'b1) pc++;
         end
         `CHK("pulses", 2 << c, pc)
      end
   endtask
   task t_idle();
      for (int s = 0; s < 3; s++)
      begin
         slp();
         `CHK("mode", RCMC_IDLE, power_mode)
         `CHK("to_pd", 2'h1, {timeout_flag, powerdown_flag})
         `CHK("cpu_osc", 3'h1, {cpu_run, fast_osc_en, slow_osc_en})
         `CHK("wdt_run", 1'b0, wdt_run)
         {ext_pin_irq, wake_timer_irq, time_base_irq} = 3'h1 << s;
         step(1);
         `CHK("mode", RCMC_SLOW, power_mode)
         {ext_pin_irq, wake_timer_irq, time_base_irq} = 3'h0;
         watchdog_clear = 1;
         step(1);
         watchdog_clear = 0;
         `CHK("pd", 1'b0, powerdown_flag)
      end
   endtask
   task t_stop();
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h13);
      `CHK("slow_en", 1'b1, slow_osc_en)
      {t2_clk_select, wake_timer_irq_en} = 2'h3;
      slp();
      `CHK("mode", RCMC_IDLE, power_mode)
      `CHK("slow_en", 1'b1, slow_osc_en)
      pin_wake();
      {t2_clk_select, wake_timer_irq_en} = 2'h0;
      slp();
      `CHK("mode", RCMC_STOP, power_mode)
      `CHK("osc", 2'h0, {fast_osc_en, slow_osc_en})
      {wake_timer_irq, time_base_irq} = 2'h3;
      step(3);
      `CHK("mode", RCMC_STOP, power_mode)
      {wake_timer_irq, time_base_irq} = 2'h0;
      pin_wake();
      `CHK("mode", RCMC_SLOW, power_mode)
   endtask
   task t_wdt();
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h01);
      slp();
      pin_wake();
      rs_seen = 0;
      wdt_overflow = 1;
      step(1);
      wdt_overflow = 0;
      settle();
      `CHK("wdt_reset", 1'b1, rs_seen)
      `CHK("to_pd", 2'h3, {timeout_flag, powerdown_flag})
      rchk(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h03);
   endtask
   task t_pin();
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h01);
      rs_seen = 0;
      ext_reset_pin_n = 0;
      step(3);
      ext_reset_pin_n = 1;
      step(10);
      `CHK("pin_reset", 1'b0, rs_seen)
      rchk(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h01);
      ext_reset_pin_n = 0;
      step(40);
      ext_reset_pin_n = 1;
      settle();
      `CHK("pin_reset", 1'b1, rs_seen)
      rchk(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h03);
      `CHK("to_pd", 2'h3, {timeout_flag, powerdown_flag})
   endtask
   task t_lvr();
      lvr_low = 1;
      step(1);
      `CHK("sys_reset", 1'b1, sys_reset)
      step(3);
      lvr_low = 0;
      settle();
      `CHK("to_pd", 2'h0, {timeout_flag, powerdown_flag})
      rchk(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h03);
      `CHK("mode", RCMC_SLOW, power_mode)
   endtask
   task t_por();
      slp();
      config_word = 16'hb300;
      rst_n = 0;
      step(2);
      rst_n = 1;
      step(2);
      `CHK("flags", 2'h0, {timeout_flag, powerdown_flag})
      `CHK("mode", RCMC_SLOW, power_mode)
      `CHK("cfg", 5'h16, {chip_mode, fast_osc_cfg, lvr_level})
      rs_seen = 0;
      ext_reset_pin_n = 0;
      step(20);
      ext_reset_pin_n = 1;
      step(4);
      `CHK("pin_off", 1'b0, rs_seen)
      wr(RCMC_CLOCK_CONTROL_REG_ADDR, 8'h13);
      slp();
      `CHK("mode", RCMC_IDLE, power_mode)
      `CHK("osc_wdt", 2'h3, {slow_osc_en, wdt_run})
      pin_wake();
   endtask
   // -----------------------------------------------------------
   // run control
   // -----------------------------------------------------------
   task stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge core_clk);
      #1 rst_n = 1;
      step(2);
      t_reset();
      t_reject();
      t_switch();
      t_psc();
      t_idle();
      t_stop();
      t_wdt();
      t_pin();
      t_lvr();
      t_por();
      stop_test();
   end
   initial
   begin
      #400000;
      err_total++;
      stop_test();
   end
endmodule
